// ===== verilog/match_based_pwm_timer.sv
// Pulse width timer: prescaler, counter, seven matches, outputs, registers
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
// Behaviour
// [R1] Seven matches drive six single edge, three double edge, or mixed outputs.
// [R2] A match may leave the counter running, optionally interrupting.
// [R3] A match may stop the counter, optionally interrupting.
// [R4] A match may reset the counter, optionally interrupting.
// [R5] Single edge outputs go high at cycle start unless constant low.
// [R6] Double edge outputs place both edges anywhere in the cycle.
// [R7] Period and width are any number of counts.
// [R8] All outputs share one repetition rate.
// [R9] Match updates follow output cycles, never producing bad pulses.
// [R10] Software releases written match values before they take effect.
// [R11] Without pulse mode the block is a plain timer with match actions.
// [R12] Thirty two bit counter behind a thirty two bit prescaler.
// [R13] The cycle rate match resets the count and starts each cycle.
// [R14] Double edge: rise before fall gives positive pulse, else negative.
// [R15] Counting comes from the system clock through the prescaler.
// [R16] Released values take effect when the cycle rate match resets the count.
// [R17] Each match has a sticky flag, cleared by writing one.
module match_based_pwm_timer #(
  parameter int unsigned CNT_W = 32
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [5:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic [5:0] pwm_o
);
  localparam int unsigned NM = pwm_timer_pkg::NUM_MATCH;
  localparam int unsigned NO = pwm_timer_pkg::NUM_OUT;

  logic [2:0] ctrl_q;
  logic [CNT_W-1:0] prescale_q;
  logic [CNT_W-1:0] presc_cnt_q;
  logic [CNT_W-1:0] count_q;
  logic [NM*3-1:0] match_ctrl_q;
  logic [NO-1:0] edge_sel_q;
  logic [NO-1:0] out_en_q;
  logic [NM-1:0] latch_q;
  logic [NM-1:0] irq_stat_q;
  logic [NM-1:0] irq_en_q;
  logic [CNT_W-1:0] shadow_q [NM];
  logic [CNT_W-1:0] active_q [NM];
  logic [NM-1:0] hit;
  logic [NM-1:0] hit_en;
  logic tick;
  logic running;
  logic any_rst;
  logic any_stop;
  logic cycle_start;
  logic wr_ctrl;
  logic [31:0] rdata_q;

  function automatic logic is_match_addr(input logic [5:0] a);
    return a >= pwm_timer_pkg::ADDR_MATCH_BASE &&
           a < pwm_timer_pkg::ADDR_MATCH_BASE + 6'(NM);
  endfunction

  function automatic logic [2:0] match_idx(input logic [5:0] a);
    return 3'(a - pwm_timer_pkg::ADDR_MATCH_BASE);
  endfunction

  // Match control holds three action bits per match
  function automatic logic mc_flag(input logic [NM*3-1:0] mc, input int unsigned i, input int unsigned f);
    return mc[i*3+f];
  endfunction

  assign running = ctrl_q[pwm_timer_pkg::CTRL_RUN_BIT] & ~ctrl_q[pwm_timer_pkg::CTRL_RESET_BIT];
  assign wr_ctrl = wr_i && addr_i == pwm_timer_pkg::ADDR_CTRL;

  // Prescaler runs on every system clock while enabled  (see [R15])
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !running) begin
      presc_cnt_q <= '0;
    end else if (presc_cnt_q >= prescale_q) begin
      presc_cnt_q <= '0;
    end else begin
      presc_cnt_q <= presc_cnt_q + 1'b1; // see [R12]
    end
  end

  assign tick = running && presc_cnt_q >= prescale_q;

  // Matches compare the count on the tick that would move it on
  genvar g;
  generate
    for (g = 0; g < NM; g++) begin : g_match
      assign hit[g] = tick && count_q == active_q[g];
      assign hit_en[g] = hit[g];
    end
  endgenerate

  always_comb begin
    any_rst = 1'b0;
    any_stop = 1'b0;
    for (int i = 0; i < NM; i++) begin
      any_rst = any_rst | (hit_en[i] & mc_flag(match_ctrl_q, i, pwm_timer_pkg::MC_RST)); // see [R4]
      any_stop = any_stop | (hit_en[i] & mc_flag(match_ctrl_q, i, pwm_timer_pkg::MC_STOP)); // see [R3]
    end
    // In pulse mode the cycle rate match always ends the cycle  (see [R13])
    if (ctrl_q[pwm_timer_pkg::CTRL_PWM_BIT] && hit[0]) begin
      any_rst = 1'b1;
    end
  end

  assign cycle_start = any_rst; // see [R8]

  // Main counter; a match with neither action just keeps counting, except match 0 in pulse mode  (see [R2])
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || ctrl_q[pwm_timer_pkg::CTRL_RESET_BIT]) begin
      count_q <= '0;
    end else if (wr_i && addr_i == pwm_timer_pkg::ADDR_COUNT) begin
      count_q <= wdata_i[CNT_W-1:0];
    end else if (any_rst) begin
      count_q <= '0; // see [R4] see [R13] see [R7]
    end else if (tick) begin
      count_q <= count_q + 1'b1; // see [R12]
    end
  end

  // Control register; a stop match drops the run bit, a write still wins
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata_i[2:0];
    end else if (any_stop) begin
      ctrl_q[pwm_timer_pkg::CTRL_RUN_BIT] <= 1'b0; // see [R3]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      prescale_q <= '0;
      match_ctrl_q <= '0;
      edge_sel_q <= '0;
      out_en_q <= '0;
      irq_en_q <= '0;
    end else if (wr_i) begin
      case (addr_i)
        pwm_timer_pkg::ADDR_PRESCALE: prescale_q <= wdata_i[CNT_W-1:0];
        pwm_timer_pkg::ADDR_MATCH_CTRL: match_ctrl_q <= wdata_i[NM*3-1:0];
        pwm_timer_pkg::ADDR_EDGE_SEL: edge_sel_q <= wdata_i[NO-1:0];
        pwm_timer_pkg::ADDR_OUT_EN: out_en_q <= wdata_i[NO-1:0];
        pwm_timer_pkg::ADDR_IRQ_ENABLE: irq_en_q <= wdata_i[NM-1:0];
        default: ;
      endcase
    end
  end

  // Shadow match values; active copies load only when released.
  // Outside pulse mode there is no cycle to align to, so a release loads at once.
  generate
    for (g = 0; g < NM; g++) begin : g_shadow
      always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
          shadow_q[g] <= '0;
          active_q[g] <= '0;
        end else begin
          if (wr_i && is_match_addr(addr_i) && match_idx(addr_i) == 3'(g)) begin
            shadow_q[g] <= wdata_i[CNT_W-1:0];
          end
          if (latch_q[g] && (cycle_start || !ctrl_q[pwm_timer_pkg::CTRL_PWM_BIT])) begin
            active_q[g] <= shadow_q[g]; // see [R9] see [R10] see [R16]
          end
        end
      end
    end
  endgenerate

  // Release bits: written by software, cleared once the value is taken
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      latch_q <= '0;
    end else if (wr_i && addr_i == pwm_timer_pkg::ADDR_LATCH) begin
      latch_q <= latch_q | wdata_i[NM-1:0]; // see [R10]
    end else if (cycle_start || !ctrl_q[pwm_timer_pkg::CTRL_PWM_BIT]) begin
      latch_q <= '0; // see [R16]
    end
  end

  // Sticky flags: a match in the clearing cycle stays set  (see [R17])
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_stat_q <= '0;
    end else begin
      for (int i = 0; i < NM; i++) begin
        if (hit_en[i] && mc_flag(match_ctrl_q, i, pwm_timer_pkg::MC_IRQ)) begin
          irq_stat_q[i] <= 1'b1; // see [R2] see [R17]
        end else if (wr_i && addr_i == pwm_timer_pkg::ADDR_IRQ_CLEAR && wdata_i[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_en_q);

  // Output n uses match n+1 as fall; double edge takes match n as rise.
  // Output 0 has no rise partner, so it is single edge only.
  generate
    for (g = 0; g < NO; g++) begin : g_out
      pwm_out_stage u_stage (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .double_i(g > 0 ? edge_sel_q[g] : 1'b0),
        .enable_i(out_en_q[g] & ctrl_q[pwm_timer_pkg::CTRL_PWM_BIT]), // see [R11]
        .cycle_start_i(cycle_start),
        .set_match_i(hit[g]), // see [R6] see [R14]
        .clr_match_i(hit[g+1]), // see [R1]
        .pwm_o(pwm_o[g])
      );
    end
  endgenerate

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !rd_i) begin
      rdata_q <= pwm_timer_pkg::RESET_WORD;
    end else if (is_match_addr(addr_i)) begin
      rdata_q <= 32'(shadow_q[match_idx(addr_i)]);
    end else begin
      case (addr_i)
        pwm_timer_pkg::ADDR_CTRL: rdata_q <= 32'(ctrl_q);
        pwm_timer_pkg::ADDR_PRESCALE: rdata_q <= 32'(prescale_q);
        pwm_timer_pkg::ADDR_PRESC_CNT: rdata_q <= 32'(presc_cnt_q);
        pwm_timer_pkg::ADDR_COUNT: rdata_q <= 32'(count_q);
        pwm_timer_pkg::ADDR_MATCH_CTRL: rdata_q <= 32'(match_ctrl_q);
        pwm_timer_pkg::ADDR_EDGE_SEL: rdata_q <= 32'(edge_sel_q);
        pwm_timer_pkg::ADDR_OUT_EN: rdata_q <= 32'(out_en_q);
        pwm_timer_pkg::ADDR_LATCH: rdata_q <= 32'(latch_q);
        pwm_timer_pkg::ADDR_IRQ_STATUS: rdata_q <= 32'(irq_stat_q);
        pwm_timer_pkg::ADDR_IRQ_ENABLE: rdata_q <= 32'(irq_en_q);
        default: rdata_q <= pwm_timer_pkg::RESET_WORD;
      endcase
    end
  end

  assign rdata_o = rdata_q;

  a_reset_match: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R4]
    hit[1] && match_ctrl_q[4] && !wr_i && !ctrl_q[1] |=> count_q == '0)
    else $error("reset match did not clear count");
  a_stop_match: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R3]
    hit[2] && match_ctrl_q[8] && !wr_ctrl |=> !ctrl_q[0])
    else $error("stop match did not halt timer");
  a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R17]
    hit[1] && match_ctrl_q[3] |=> irq_stat_q[1])
    else $error("match flag not set");
  a_irq_level: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R2]
    irq_en_q[1] && hit[1] && match_ctrl_q[3] && !wr_i |=> irq_o)
    else $error("enabled match did not raise interrupt");
  a_cycle_wrap: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R13]
    ctrl_q[2] && hit[0] && !wr_i && !ctrl_q[1] |=> count_q == '0)
    else $error("cycle rate match did not restart");
  a_hold_shadow: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R10]
    ctrl_q[2] && !latch_q[1] |=> $stable(active_q[1]))
    else $error("match value changed without release");
  a_timer_mode: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R11]
    !ctrl_q[2] |-> pwm_o == '0)
    else $error("pulse output active outside pulse mode");
  a_count_up: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R12]
    tick && !any_rst && !wr_i && !ctrl_q[1] |=> count_q == $past(count_q) + 1'b1)
    else $error("count did not advance on tick");
  // Prescaler, counter, control, release, output edge and flag checks
  a_presc_wrap: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R15]
    tick
    |=> presc_cnt_q == '0)
    else $error("prescaler did not wrap on tick");
  a_presc_step: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R15]
    running && presc_cnt_q < prescale_q
    |=> presc_cnt_q == $past(presc_cnt_q) + 1'b1)
    else $error("prescaler did not step");
  a_presc_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R15]
    !running
    |=> presc_cnt_q == '0)
    else $error("prescaler moved while halted");
  a_count_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R12]
    !tick && !wr_i && !ctrl_q[1]
    |=> $stable(count_q))
    else $error("count moved without tick");
  a_count_clear: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R12]
    ctrl_q[1]
    |=> count_q == '0)
    else $error("counter reset bit did not hold count at zero");
  a_ctrl_write: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R3]
    wr_ctrl
    |=> ctrl_q == $past(wdata_i[2:0]))
    else $error("control write lost");
  a_stop_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R3]
    !ctrl_q[0] && !ctrl_q[1] && !wr_i
    |=> $stable(count_q))
    else $error("stopped timer kept counting");
  a_release_load: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R16]
    ctrl_q[2] && latch_q[1] && cycle_start
    |=> active_q[1] == $past(shadow_q[1]))
    else $error("released value not taken at cycle start");
  a_release_clear: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R10]
    ctrl_q[2] && cycle_start && !wr_i
    |=> latch_q == '0)
    else $error("release bits not cleared at cycle start");
  a_timer_load: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R11]
    !ctrl_q[2] && latch_q[1]
    |=> active_q[1] == $past(shadow_q[1]))
    else $error("timer mode release not taken");
  a_single_set: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R5]
    ctrl_q[2] && !edge_sel_q[1] && out_en_q[1] && cycle_start && !hit[2] && !wr_i
    |=> pwm_o[1])
    else $error("single edge output not set at cycle start");
  a_shared_start: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R8]
    ctrl_q[2] && out_en_q[0] && cycle_start && !hit[1] && !wr_i
    |=> pwm_o[0])
    else $error("output zero missed the shared cycle start");
  a_double_rise: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R14]
    ctrl_q[2] && edge_sel_q[2] && out_en_q[2] && hit[2] && !hit[3] && !wr_i
    |=> pwm_o[2])
    else $error("double edge output did not rise on its match");
  a_fall_clear: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R6]
    ctrl_q[2] && out_en_q[2] && hit[3]
    |=> !pwm_o[2])
    else $error("output did not fall on its match");
  a_double_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R6]
    edge_sel_q[2] && !hit[2] && !hit[3] && !wr_i
    |=> $stable(pwm_o[2]))
    else $error("double edge output moved between its matches");
  a_single_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R5]
    !edge_sel_q[1] && !cycle_start && !hit[2] && !wr_i
    |=> $stable(pwm_o[1]))
    else $error("single edge output moved between its edges");
  a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (srst_i) // see [R17]
    wr_i && addr_i == pwm_timer_pkg::ADDR_IRQ_CLEAR && wdata_i[1] && !(hit[1] && match_ctrl_q[3])
    |=> !irq_stat_q[1])
    else $error("match flag not cleared by write");
  c_cycle: cover property (@(posedge clk_sys_i) ctrl_q[2] && cycle_start);
  c_release: cover property (@(posedge clk_sys_i) latch_q[0] && cycle_start);
  c_irq: cover property (@(posedge clk_sys_i) irq_o);
  c_double: cover property (@(posedge clk_sys_i) edge_sel_q[2] && pwm_o[2]);
  c_stop: cover property (@(posedge clk_sys_i) any_stop);
endmodule

// ===== verilog/pwm_timer_pkg.sv
// Constants shared by the match based pulse width timer
package pwm_timer_pkg;
  localparam int unsigned NUM_MATCH = 7;
  localparam int unsigned NUM_OUT = 6;
  localparam int unsigned ADDR_W = 6;
  // Register word addresses
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_PRESCALE = 6'h01;
  localparam logic [5:0] ADDR_PRESC_CNT = 6'h02;
  localparam logic [5:0] ADDR_COUNT = 6'h03;
  localparam logic [5:0] ADDR_MATCH_CTRL = 6'h04;
  localparam logic [5:0] ADDR_EDGE_SEL = 6'h05;
  localparam logic [5:0] ADDR_OUT_EN = 6'h06;
  localparam logic [5:0] ADDR_LATCH = 6'h07;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h08;
  localparam logic [5:0] ADDR_IRQ_CLEAR = 6'h09;
  localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h0a;
  localparam logic [5:0] ADDR_MATCH_BASE = 6'h10;
  // Control register fields
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_RESET_BIT = 1;
  localparam int unsigned CTRL_PWM_BIT = 2;
  // Match control: three bits per match, irq / reset / stop
  localparam int unsigned MC_IRQ = 0;
  localparam int unsigned MC_RST = 1;
  localparam int unsigned MC_STOP = 2;
  localparam int unsigned MC_W = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// ===== verilog/pwm_out_stage.sv
// One pulse output: single or double edge set/reset flop
`timescale 1ns/1ps
module pwm_out_stage (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic double_i,
  input wire logic enable_i,
  input wire logic cycle_start_i,
  input wire logic set_match_i,
  input wire logic clr_match_i,
  output logic pwm_o
);
  logic level_q;
  logic set_now;

  // Single edge sets at cycle start, double edge sets on its own match
  assign set_now = double_i ? set_match_i : cycle_start_i;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      level_q <= 1'b0;
    end else if (clr_match_i) begin
      // Clear wins a tie so a zero width stays constant low  (see [R5])
      level_q <= 1'b0;
    end else if (set_now) begin
      level_q <= 1'b1; // see [R5] see [R14]
    end
  end

  assign pwm_o = level_q & enable_i;
endmodule

// ===== verification/pwm_load_model.sv
// Load model on the pulse outputs: counts high clocks and rising edges per output
`timescale 1ns/1ps
module pwm_load_model (
  input wire logic clk_sys_i,
  input wire logic clr_i,
  input wire logic [5:0] pwm_i,
  output logic [5:0][15:0] high_cnt_o,
  output logic [5:0][15:0] rise_cnt_o
);
  logic [5:0] prev_q;
  // A load only observes; previous level keeps running so a window opening mid-pulse sees no false edge
  always_ff @(posedge clk_sys_i) begin
    prev_q <= pwm_i;
    for (int n = 0; n < 6; n++) begin
      if (clr_i) begin
        high_cnt_o[n] <= 16'h0000;
        rise_cnt_o[n] <= 16'h0000;
      end else begin
        high_cnt_o[n] <= high_cnt_o[n] + {15'h0000, pwm_i[n]};
        rise_cnt_o[n] <= rise_cnt_o[n] + {15'h0000, pwm_i[n] & ~prev_q[n]};
      end
    end
  end
endmodule

// ===== verification/match_based_pwm_timer_tb.sv
// Self-checking bench for the match based pulse width timer
`timescale 1ns/1ps
module match_based_pwm_timer_tb;
  logic clk_sys_i, wr_i, rd_i, clr;
  logic srst_i = 1'b1;
  logic [5:0] addr_i = 6'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic [31:0] rdata_o, d, e;
  logic irq_o;
  logic [5:0] pwm_o;
  logic [5:0][15:0] high_cnt, rise_cnt;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  match_based_pwm_timer DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .pwm_o(pwm_o));
  pwm_load_model LOAD (.clk_sys_i(clk_sys_i), .clr_i(clr), .pwm_i(pwm_o), .high_cnt_o(high_cnt),
    .rise_cnt_o(rise_cnt));
  initial begin
    clk_sys_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    clr = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // Whole run is about a thousand cycles; a hang stops here
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rst();
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
  endtask
  task automatic wm(input int k, input logic [31:0] v);
    wr(pwm_timer_pkg::ADDR_MATCH_BASE + 6'(k), v);
  endtask
  // Settle first, then count exactly n clocks in the load model
  task automatic measure(input int n);
    repeat (20) @(posedge clk_sys_i);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic t_regs();
    rst();
    #1 chk({25'h0, irq_o, pwm_o}, 32'h0);
    rd(pwm_timer_pkg::ADDR_COUNT);
    chk(d, 32'h0);
    wr(pwm_timer_pkg::ADDR_COUNT, 32'h0000_1234);
    rd(pwm_timer_pkg::ADDR_COUNT);
    chk(d, 32'h0000_1234);
    wr(pwm_timer_pkg::ADDR_PRESCALE, 32'hffff_ffff);
    rd(pwm_timer_pkg::ADDR_PRESCALE);
    chk(d, 32'hffff_ffff);
    wr(6'h3f, 32'h1234_5678);
    rd(6'h3f);
    chk(d, 32'h0);
  endtask
  task automatic t_cont();
    rst();
    wm(1, 32'h5);
    wr(pwm_timer_pkg::ADDR_MATCH_CTRL, 32'h8);
    wr(pwm_timer_pkg::ADDR_IRQ_ENABLE, 32'h2);
    wr(pwm_timer_pkg::ADDR_LATCH, 32'h2);
    wr(pwm_timer_pkg::ADDR_CTRL, 32'h1);
    for (int i = 0; i < 30 && irq_o !== 1'b1; i++) @(posedge clk_sys_i);
    #1 chk(irq_o, 1'b1);
    rd(pwm_timer_pkg::ADDR_COUNT);
    e = d;
    rd(pwm_timer_pkg::ADDR_COUNT);
    chk(d > e, 1'b1);
    rd(pwm_timer_pkg::ADDR_IRQ_STATUS);
    chk(d, 32'h2);
    wr(pwm_timer_pkg::ADDR_IRQ_CLEAR, 32'h2);
    rd(pwm_timer_pkg::ADDR_IRQ_STATUS);
    chk({d[31:1], irq_o}, 32'h0);
  endtask
  task automatic t_stop();
    rst();
    wm(2, 32'h4);
    wr(pwm_timer_pkg::ADDR_MATCH_CTRL, 32'h140);
    wr(pwm_timer_pkg::ADDR_LATCH, 32'h4);
    wr(pwm_timer_pkg::ADDR_CTRL, 32'h1);
    repeat (20) @(posedge clk_sys_i);
    rd(pwm_timer_pkg::ADDR_COUNT);
    e = d;
    rd(pwm_timer_pkg::ADDR_COUNT);
    chk(d, e);
    rd(pwm_timer_pkg::ADDR_CTRL);
    chk(d, 32'h0);
    chk(irq_o, 1'b0);
    wr(pwm_timer_pkg::ADDR_IRQ_ENABLE, 32'h4);
    @(posedge clk_sys_i);
    #1 chk(irq_o, 1'b1);
  endtask
  task automatic t_rstm();
    rst();
    wm(1, 32'h2);
    wr(pwm_timer_pkg::ADDR_MATCH_CTRL, 32'h10);
    wr(pwm_timer_pkg::ADDR_LATCH, 32'h2);
    wr(pwm_timer_pkg::ADDR_CTRL, 32'h1);
    repeat (4) begin
      rd(pwm_timer_pkg::ADDR_COUNT);
      chk(d < 3, 1'b1);
    end
    wr(pwm_timer_pkg::ADDR_CTRL, 32'h3);
    rd(pwm_timer_pkg::ADDR_COUNT);
    chk(d, 32'h0);
  endtask
  // Prescale 2: a count lasts three clocks, a period of four counts is 12 clocks, output 0 high for 6
  task automatic t_presc();
    rst();
    wr(pwm_timer_pkg::ADDR_PRESCALE, 32'h2);
    wm(0, 32'h3);
    wm(1, 32'h1);
    wr(pwm_timer_pkg::ADDR_OUT_EN, 32'h1);
    wr(pwm_timer_pkg::ADDR_LATCH, 32'h3);
    wr(pwm_timer_pkg::ADDR_CTRL, 32'h5);
    measure(120);
    chk(high_cnt[0], 60);
    chk(rise_cnt[0], 10);
  endtask
  // Period 8 counts; output n cleared by match n+1 = n+1, so high n+2 clocks of 8
  task automatic t_single(input logic pm);
    rst();
    wm(0, 32'h7);
    for (int k = 1; k < 7; k++) wm(k, k);
    wr(pwm_timer_pkg::ADDR_OUT_EN, 32'h3f);
    wr(pwm_timer_pkg::ADDR_LATCH, 32'h7f);
    wr(pwm_timer_pkg::ADDR_CTRL, pm ? 32'h5 : 32'h1);
    measure(80);
    for (int n = 0; n < 6; n++) begin
      chk(high_cnt[n], pm ? 10 * (n + 2) : 0);
      chk(rise_cnt[n], pm ? 10 : 0);
    end
  endtask
  // Written but unreleased value must not act; after release it takes over at cycle start
  task automatic t_release();
    wm(1, 32'h3);
    rd(pwm_timer_pkg::ADDR_MATCH_BASE + 6'h01);
    chk(d, 32'h3);
    measure(80);
    chk(high_cnt[0], 20);
    wr(pwm_timer_pkg::ADDR_LATCH, 32'h2);
    measure(80);
    chk(high_cnt[0], 40);
    chk(rise_cnt[0], 10);
  endtask
  task automatic t_double(input logic [31:0] r, input logic [31:0] f, input int exp);
    rst();
    wm(0, 32'h9);
    wm(2, r);
    wm(3, f);
    wr(pwm_timer_pkg::ADDR_EDGE_SEL, 32'h4);
    wr(pwm_timer_pkg::ADDR_OUT_EN, 32'h4);
    wr(pwm_timer_pkg::ADDR_LATCH, 32'hd);
    wr(pwm_timer_pkg::ADDR_CTRL, 32'h5);
    measure(100);
    chk(high_cnt[2], exp);
    chk(rise_cnt[2], 10);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_regs();
    t_cont();
    t_stop();
    t_rstm();
    t_single(1'b0);
    t_single(1'b1);
    t_release();
    t_double(32'h2, 32'h6, 40);
    t_double(32'h6, 32'h2, 60);
    t_presc();
    test_done();
  end
endmodule
